// [tcs_pkg.sv]
// Constants and carrier types for the shutdown channel select block
package tcs_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_CH1 = 8'h04;
  localparam logic [7:0] OFS_CH2 = 8'h08;
  localparam logic [7:0] OFS_CH3 = 8'h0C;
  localparam logic [7:0] OFS_CFG2 = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_STRAP = 8'h1C;
  localparam logic [7:0] OFS_TEMP = 8'h20;
  localparam logic [7:0] OFS_TRIP = 8'h30;
  localparam logic [7:0] OFS_NONE = 8'hFC;
  localparam logic [23:0] ADDR_HI_ZERO = 24'h00_0000;
  localparam logic HRESP_OKAY = 1'b0;
  // Status and mask layout
  localparam int ST_OT = 0;
  localparam int ST_DF0 = 1;
  localparam int NST = 5;
  localparam logic [NST-1:0] MASK_RST = 5'h00;
  // Temperature word: [10:3] signed integer, [2:0] fraction
  localparam int TW = 11;
  localparam int FRAC = 3;
  localparam logic [7:0] FAULT_HI = 8'h80;
  localparam logic [FRAC-1:0] FRAC_ZERO = 3'h0;
  localparam logic [4:0] LO_PAD = 5'h00;
  // Trip threshold span in degrees C
  localparam logic [7:0] TRIP_MIN = 8'h3C;
  localparam logic [7:0] TRIP_MAX = 8'h7A;
  localparam logic [5:0] TRIP_SPAN = 6'h3E;
  // Averaging factors relative to one 11-bit conversion
  localparam logic [3:0] AVG_1X = 4'h1;
  localparam logic [3:0] AVG_2X = 4'h2;
  localparam logic [3:0] AVG_4X = 4'h4;
  localparam logic [3:0] AVG_8X = 4'h8;

  typedef enum logic [1:0] {
    STRAP_LOW = 2'b00,
    STRAP_HIGH = 2'b01,
    STRAP_OPEN = 2'b10
  } tcs_strap_e;

  typedef enum logic [1:0] {
    RATE_1PS = 2'b00,
    RATE_2PS = 2'b01,
    RATE_4PS = 2'b10,
    RATE_8PS = 2'b11
  } tcs_rate_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DATA = 2'b01
  } tcs_bus_e;

  typedef struct packed {
    logic apd;
    logic res_corr_auto;
    logic res_corr_en;
    logic beta_auto;
    logic beta_en;
  } tcs_chcfg_s;

  typedef struct packed {
    logic [1:0] qdepth;
    logic avg_dis;
    logic dyn_en;
    tcs_rate_e rate;
  } tcs_cfg2_s;

  typedef struct packed {
    logic valid;
    logic [1:0] ch;
    logic open_ckt;
    logic short_ckt;
    logic [TW-1:0] temp;
  } tcs_meas_s;

  localparam tcs_chcfg_s CFG_RST = 5'h0F;
  localparam tcs_chcfg_s CFG_SUBSTRATE = 5'h0F;
  localparam tcs_chcfg_s CFG_PLAIN = 5'h00;
  localparam tcs_chcfg_s CFG_EXT2 = 5'h0F;
  localparam tcs_cfg2_s CFG2_RST = 6'h07;
endpackage : tcs_pkg

// [tcs_avg4.sv]
// Four-sample running average filter for external channel one
`timescale 1ns/10ps
module tcs_avg4
  import tcs_pkg::*;
(
  input wire logic CLK, // core clock
  input wire logic RST_B, // synchronous reset, active low
  input wire logic PUSH, // good sample accepted this cycle
  input wire logic AVG_DIS, // bypass the filter
  input wire logic [tcs_pkg::TW-1:0] SAMPLE, // newest sample
  output logic [tcs_pkg::TW-1:0] AVG // filtered value for this sample
);
  typedef struct packed {
    logic primed;
    logic [2:0][TW-1:0] hist;
  } tcs_avg_s;

  tcs_avg_s st;
  tcs_avg_s nx;
  logic signed [TW+1:0] sum;

  always_comb
  begin
    nx = st;
    sum = $signed({{2{SAMPLE[TW-1]}}, SAMPLE});
    for (int i = 0; i < 3; i++)
      sum = sum + $signed({{2{st.hist[i][TW-1]}}, st.hist[i]});
    // Before the first sample the history is empty, so pass it through
    if (AVG_DIS || !st.primed)
      AVG = SAMPLE;
    else
      AVG = TW'(sum >>> 2);
    if (PUSH)
    begin
      nx.primed = 1'b1;
      // The first sample fills the whole history so the mean starts flat
      nx.hist[0] = SAMPLE;
      for (int i = 1; i < 3; i++)
        nx.hist[i] = st.primed ? st.hist[i-1] : SAMPLE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      st <= '0;
    else
      st <= nx;
  end
endmodule : tcs_avg4

// [tcs_shutdown_ctl.sv]
// Strap decode, channel lock, over-temperature queue and register slave
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module tcs_shutdown_ctl
  import tcs_pkg::*;
(
  input wire logic CORE_CLK, // core clock, 20 MHz
  input wire logic RST_B, // synchronous reset, active low
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size, word only
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic HREADYOUT, // AHB slave ready
  output logic [31:0] HRDATA, // AHB read data
  output logic HRESP, // AHB response, always OKAY
  input wire logic STRAP_PU_LVL, // strap level seen with weak pull-up
  input wire logic STRAP_PD_LVL, // strap level seen with weak pull-down
  input wire logic [5:0] TRIP_CODE, // trip setting code from the front end
  input wire tcs_pkg::tcs_meas_s MEAS, // measurement result strobe
  output logic HW_OVERTEMP, // qualified over-temperature flag
  output logic IRQ, // level interrupt
  output tcs_pkg::tcs_chcfg_s [3:1] CH_CFG, // per-channel front-end config
  output logic [3:0] AVG_FACTOR, // external averaging factor
  output logic [1:0] CONV_RATE, // conversion rate select
  output logic [1:0] SHDN_CH, // channel feeding shutdown
  output logic CH3_EN // channel three measured
);
  import tcs_pkg::*;

  typedef struct packed {
    tcs_strap_e strap;
    logic strap_done;
    logic [1:0] shdn_ch;
    tcs_chcfg_s [3:1] cfg;
    tcs_cfg2_s cfg2;
    logic [NST-1:0] status;
    logic [NST-1:0] mask;
    logic [3:0][TW-1:0] temp;
    logic [7:0] trip;
    logic [1:0] qcnt;
    logic ot;
    logic irq;
    logic [3:0] avg_factor;
    tcs_bus_e bus;
    logic b_wr;
    logic [7:0] b_addr;
    logic [31:0] rdata;
    logic ready;
  } tcs_state_s;

  tcs_state_s st;
  tcs_state_s nx;
  logic fault;
  logic take;
  logic sel;
  logic hot;
  logic cold;
  logic [TW-1:0] avg_out;
  logic [TW-1:0] newv;
  logic [TW-1:0] trip_w;
  logic [31:0] rd;

  // Good channel one samples feed the filter; faults bypass it
  tcs_avg4 u_avg (
    .CLK(CORE_CLK),
    .RST_B(RST_B),
    .PUSH(take && MEAS.ch == 2'd1 && !fault),
    .AVG_DIS(st.cfg2.avg_dis),
    .SAMPLE(MEAS.temp),
    .AVG(avg_out)
  );

  always_comb
  begin
    nx = st;
    rd = '0;
    fault = MEAS.open_ckt | MEAS.short_ckt;
    // Channel three samples are dropped without an anti-parallel pair
    take = MEAS.valid && st.strap_done && !(MEAS.ch == 2'd3 && !st.cfg[2].apd);
    sel = take && MEAS.ch == st.shdn_ch;
    newv = MEAS.temp;
    trip_w = {st.trip, FRAC_ZERO};
    hot = 1'b0;
    cold = 1'b0;

    // Strap decode: a floating pin follows whichever weak pull is applied
    if (!st.strap_done)
    begin
      nx.strap_done = 1'b1;
      if (STRAP_PU_LVL != STRAP_PD_LVL)
        nx.strap = STRAP_OPEN;
      else if (STRAP_PU_LVL)
        nx.strap = STRAP_HIGH;
      else
        nx.strap = STRAP_LOW;
    end

    // Read mux
    case (st.b_addr)
      OFS_CH1: rd = 32'(st.cfg[1]);
      OFS_CH2: rd = 32'(st.cfg[2]);
      OFS_CH3: rd = 32'(st.cfg[3]);
      OFS_CFG2: rd = 32'(st.cfg2);
      OFS_STAT: rd = 32'(st.status);
      OFS_MASK: rd = 32'(st.mask);
      OFS_STRAP: rd = 32'({st.shdn_ch, st.strap});
      OFS_TRIP: rd = 32'(st.trip);
      default:
      begin
        if (st.b_addr[7:4] == OFS_TEMP[7:4])
          rd = 32'({st.temp[st.b_addr[3:2]][TW-1:FRAC], st.temp[st.b_addr[3:2]][FRAC-1:0],
                    LO_PAD});
        else
          rd = '0;
      end
    endcase

    // Bus data phase: one wait cycle, then the answer
    case (st.bus)
      BUS_IDLE:
        nx.ready = 1'b1;
      BUS_DATA:
      begin
        nx.bus = BUS_IDLE;
        nx.ready = 1'b1;
        if (!st.b_wr)
          nx.rdata = rd;
        else
        begin
          case (st.b_addr)
            OFS_CH1: if (st.shdn_ch != 2'd1) nx.cfg[1] = HWDATA[4:0];
            OFS_CH2: if (st.shdn_ch != 2'd2) nx.cfg[2] = HWDATA[4:0];
            OFS_CH3: nx.cfg[3] = HWDATA[4:0];
            OFS_CFG2: nx.cfg2 = HWDATA[5:0];
            OFS_STAT: nx.status = st.status & ~HWDATA[NST-1:0];
            OFS_MASK: nx.mask = HWDATA[NST-1:0];
            default: nx.bus = BUS_IDLE; // Read-only and unmapped offsets drop writes
          endcase
        end
      end
      default:
      begin
        nx.bus = BUS_IDLE;
        nx.ready = 1'b1;
      end
    endcase
    if (HSEL && HTRANS[1] && HREADY)
    begin
      nx.bus = BUS_DATA;
      nx.ready = 1'b0;
      nx.b_wr = HWRITE;
      nx.b_addr = (HADDR[31:8] == ADDR_HI_ZERO) ? HADDR[7:0] : OFS_NONE;
    end

    // Locked channel preset overrides anything written this cycle
    if (nx.strap_done)
    begin
      case (nx.strap)
        STRAP_LOW:
        begin
          nx.shdn_ch = 2'd1;
          nx.cfg[1] = CFG_SUBSTRATE;
        end
        STRAP_OPEN:
        begin
          nx.shdn_ch = 2'd1;
          nx.cfg[1] = CFG_PLAIN;
        end
        STRAP_HIGH:
        begin
          nx.shdn_ch = 2'd2;
          nx.cfg[2] = CFG_EXT2;
        end
        default:
          nx.shdn_ch = 2'd1;
      endcase
    end

    // Trip point from the setting code, clamped at the top
    if (TRIP_CODE > TRIP_SPAN)
      nx.trip = TRIP_MAX;
    else
      nx.trip = TRIP_MIN + {2'b00, TRIP_CODE};

    // Measurement capture
    if (take)
    begin
      if (fault)
      begin
        newv = {FAULT_HI, FRAC_ZERO};
        nx.status[ST_DF0 + int'(MEAS.ch)] = 1'b1;
      end
      else if (MEAS.ch == 2'd1)
        newv = avg_out;
      nx.temp[MEAS.ch] = newv;
    end

    // Fault queue; a faulted reading counts as cold
    hot = sel && ($signed(newv) > $signed(trip_w));
    cold = sel && ($signed(newv) < $signed(trip_w));
    if (!st.ot)
    begin
      if (hot && st.qcnt == st.cfg2.qdepth)
      begin
        nx.ot = 1'b1;
        nx.qcnt = '0;
        nx.status[ST_OT] = 1'b1;
      end
      else if (hot)
        nx.qcnt = st.qcnt + 2'd1;
      else if (sel)
        nx.qcnt = '0;
    end
    else if (cold)
      nx.ot = 1'b0;

    // Averaging factor follows the conversion rate
    if (!nx.cfg2.dyn_en)
      nx.avg_factor = AVG_1X;
    else
    begin
      case (nx.cfg2.rate)
        RATE_1PS: nx.avg_factor = AVG_8X;
        RATE_2PS: nx.avg_factor = AVG_4X;
        RATE_4PS: nx.avg_factor = AVG_2X;
        RATE_8PS: nx.avg_factor = AVG_1X;
        default: nx.avg_factor = AVG_1X;
      endcase
    end

    nx.irq = |(nx.status & nx.mask);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      st <= '0;
      st.cfg <= {CFG_RST, CFG_RST, CFG_RST};
      st.cfg2 <= CFG2_RST;
      st.mask <= MASK_RST;
      st.trip <= TRIP_MIN;
      st.avg_factor <= AVG_1X;
      st.shdn_ch <= 2'd1;
      st.ready <= 1'b1;
    end
    else
      st <= nx;
  end

  // Every output except HRESP, which is tied to OKAY, comes straight from the state register
  assign HREADYOUT = st.ready;
  assign HRDATA = st.rdata;
  assign HRESP = HRESP_OKAY;
  assign HW_OVERTEMP = st.ot;
  assign IRQ = st.irq;
  assign CH_CFG = st.cfg;
  assign AVG_FACTOR = st.avg_factor;
  assign CONV_RATE = st.cfg2.rate;
  assign SHDN_CH = st.shdn_ch;
  assign CH3_EN = st.cfg[2].apd;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  AST_LOCK_HOLD: assert property (
    st.strap_done && $past(st.strap_done) |-> $stable(st.cfg[st.shdn_ch]))
    else $error("locked channel config changed");
  AST_STRAP_LOW: assert property (
    st.strap_done && st.strap == STRAP_LOW |-> st.shdn_ch == 2'd1 && st.cfg[1] == CFG_SUBSTRATE)
    else $error("strap low preset wrong");
  AST_STRAP_OPEN: assert property (
    st.strap_done && st.strap == STRAP_OPEN |-> st.shdn_ch == 2'd1 && st.cfg[1] == CFG_PLAIN)
    else $error("strap open preset wrong");
  AST_STRAP_HIGH: assert property (
    st.strap_done && st.strap == STRAP_HIGH |-> st.shdn_ch == 2'd2 && st.cfg[2] == CFG_EXT2)
    else $error("strap high preset wrong");
  AST_STRAP_HOLD: assert property (
    st.strap_done |=> st.strap_done && $stable(st.strap))
    else $error("strap changed after capture");
  AST_FLAG_RISE: assert property (
    !st.ot && !(hot && st.qcnt == st.cfg2.qdepth) |=> !st.ot)
    else $error("flag rose without a full queue");
  AST_FLAG_FALL: assert property (
    st.ot && cold |=> !st.ot)
    else $error("flag did not drop on cold reading");
  AST_QUEUE_CLR: assert property (
    !st.ot && sel && !hot |=> st.qcnt == 2'd0 && !st.ot)
    else $error("queue count not cleared");
  AST_AVG_OFF: assert property (
    !st.cfg2.dyn_en |-> AVG_FACTOR == AVG_1X)
    else $error("averaging factor not 1x when disabled");
  AST_FAULT: assert property (
    take && fault |=> st.temp[$past(MEAS.ch)][TW-1:FRAC] == FAULT_HI
      && st.status[ST_DF0 + int'($past(MEAS.ch))])
    else $error("diode fault not forced");
  AST_CH3_DROP: assert property (
    MEAS.valid && MEAS.ch == 2'd3 && !st.cfg[2].apd |=> $stable(st.temp[3]))
    else $error("channel three stored without pair");
  AST_IRQ: assert property (
    IRQ == |(st.status & st.mask))
    else $error("interrupt does not follow status and mask");
  AST_TRIP_RANGE: assert property (
    st.trip >= TRIP_MIN && st.trip <= TRIP_MAX)
    else $error("trip threshold outside its span");
  AST_AVG_SLOW: assert property (
    st.cfg2.dyn_en && st.cfg2.rate == RATE_1PS |-> AVG_FACTOR == AVG_8X)
    else $error("averaging factor not 8x at the slowest rate");
  // One wait state per transfer keeps the read mux off the address decode path
  AST_BUS_WAIT: assert property (
    HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 HREADYOUT)
    else $error("bus answer not after exactly one wait state");
  AST_RDATA_HOLD: assert property (
    st.bus == BUS_IDLE |=> $stable(HRDATA))
    else $error("read data changed outside a read answer");

  COV_TRIP: cover property ($rose(st.ot));
  COV_FAULT: cover property (take && fault);
  COV_CH3_TAKEN: cover property (take && MEAS.ch == 2'd3);
  COV_LOCKED_WR: cover property (st.bus == BUS_DATA && st.b_wr && st.b_addr == OFS_CH1
    && st.shdn_ch == 2'd1);
endmodule : tcs_shutdown_ctl

// [tcs_front_model.sv]
// Remote diode front end model: strap pin levels and measurement strobes
`timescale 1ns/10ps
module tcs_front_model
  import tcs_pkg::*;
(
  input wire logic CLK, // core clock
  input wire tcs_pkg::tcs_strap_e STRAP, // strap wiring
  output logic PU_LVL, // pin level under weak pull-up
  output logic PD_LVL, // pin level under weak pull-down
  output tcs_pkg::tcs_meas_s MEAS // measurement strobe
);
  // An open pin follows whichever weak pull is applied
  assign PU_LVL = (STRAP != STRAP_LOW);
  assign PD_LVL = (STRAP == STRAP_HIGH);
  initial MEAS = '0;

  task automatic meas(input logic [1:0] ch, input logic op, input logic sh,
                      input logic [TW-1:0] t);
    @(posedge CLK);
    MEAS <= '{1'b1, ch, op, sh, t};
    @(posedge CLK);
    // Lines after the strobe carry junk, so stale data cannot pass as valid
    MEAS.valid <= 1'b0;
    MEAS.temp <= ~t;
  endtask : meas
endmodule : tcs_front_model

// [tcs_shutdown_ctl_test.sv]
// Self-checking bench for the shutdown channel select block
`timescale 1ns/10ps
module tcs_shutdown_ctl_test;
  import tcs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [2:0] hsize = 3'h2;
  logic [5:0] trip_code = 6'h14;
  tcs_strap_e strap = STRAP_LOW;
  logic hready, hresp, ot, irq, ch3_en, pu, pd;
  logic [1:0] conv_rate, shdn_ch;
  logic [31:0] hrdata, rd;
  logic [3:0] avg_factor;
  tcs_meas_s meas;
  tcs_chcfg_s [3:1] ch_cfg;
  int bad_count = 0;
  int comparisons = 0;
  int q, f, sk, t, e, lk, pv;
  int hist[$];
  int seq[8] = '{641, 700, 640, 650, 660, 641, 640, 639};
  tcs_strap_e sl[3] = '{STRAP_LOW, STRAP_HIGH, STRAP_OPEN};

  tcs_shutdown_ctl tcs_shutdown_ctl_inst (.CORE_CLK(clk), .RST_B(rst_b), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp),
    .STRAP_PU_LVL(pu), .STRAP_PD_LVL(pd), .TRIP_CODE(trip_code), .MEAS(meas),
    .HW_OVERTEMP(ot), .IRQ(irq), .CH_CFG(ch_cfg), .AVG_FACTOR(avg_factor),
    .CONV_RATE(conv_rate), .SHDN_CH(shdn_ch), .CH3_EN(ch3_en));

  tcs_front_model tcs_front_model_inst (.CLK(clk), .STRAP(strap), .PU_LVL(pu),
    .PD_LVL(pd), .MEAS(meas));

  initial forever #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {ADDR_HI_ZERO, ofs};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic mz(input int ch, input logic o, input logic s, input int v);
    tcs_front_model_inst.meas(2'(ch), o, s, 11'(v));
    @(posedge clk);
  endtask : mz

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    #(50 * 6000);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(34365));
    foreach (sl[j])
    begin
      strap <= sl[j];
      rst_b <= 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      lk = (sl[j] == STRAP_HIGH) ? 2 : 1;
      pv = (sl[j] == STRAP_OPEN) ? 0 : 15;
      chk("shdn_ch", lk, shdn_ch);
      for (int k = 1; k <= 3; k++)
        chk("ch_cfg", (k == lk) ? pv : 15, ch_cfg[k]);
      bus(1'b1, OFS_CH1 + 8'(4 * lk - 4), 32'h0000_0015);
      bus(1'b0, OFS_CH1 + 8'(4 * lk - 4), '0);
      chk("locked_cfg", pv, rd);
      bus(1'b1, OFS_CH3, 32'h0000_0003);
      bus(1'b0, OFS_CH3, '0);
      chk("free_cfg", 3, rd);
      strap <= (sl[j] == STRAP_HIGH) ? STRAP_LOW : STRAP_HIGH;
      bus(1'b0, OFS_STRAP, '0);
      chk("strap", lk * 4 + int'(sl[j]), rd);
      if (sl[j] == STRAP_LOW)
      begin
        hist.delete();
        for (int i = 0; i < 7; i++)
        begin
          t = 4 * ($urandom % 200);
          if (i == 6)
            bus(1'b1, OFS_CFG2, 32'h0000_000F);
          mz(1, 1'b0, 1'b0, t);
          hist.push_back(t);
          if (hist.size() > 4)
            void'(hist.pop_front());
          e = (i == 6) ? t : hist.sum() / 4;
          bus(1'b0, OFS_TEMP + 8'h04, '0);
          if (i >= 3)
            chk("ch1_temp", e << 5, rd);
        end
        mz(3, 1'b0, 1'b0, 400);
        bus(1'b0, OFS_TEMP + 8'h0C, '0);
        chk("ch3_off", 0, rd);
        bus(1'b1, OFS_CH2, 32'h0000_001F);
        @(posedge clk);
        chk("ch3_en", 1, ch3_en);
        mz(3, 1'b0, 1'b0, 400);
        bus(1'b0, OFS_TEMP + 8'h0C, '0);
        chk("ch3_on", 400 << 5, rd);
      end
      else if (sl[j] == STRAP_HIGH)
      begin
        // Trip 80 degrees, queue of three readings
        bus(1'b1, OFS_MASK, 32'h0000_0001);
        bus(1'b1, OFS_CFG2, 32'h0000_0027);
        q = 0;
        f = 0;
        sk = 0;
        for (int i = 0; i < 28; i++)
        begin
          t = (i < 8) ? seq[i] : 620 + $urandom % 41;
          mz(2, 1'b0, 1'b0, t);
          if (f == 0)
          begin
            q = (t > 640) ? q + 1 : 0;
            f = (q == 3);
            sk = sk | f;
          end
          else if (t < 640)
          begin
            f = 0;
            q = 0;
          end
          chk("overtemp", f, ot);
        end
        @(posedge clk);
        chk("irq", sk, irq);
        bus(1'b1, OFS_STAT, 32'h0000_0001);
        @(posedge clk);
        chk("irq_clr", 0, irq);
        for (int i = 0; i < 5; i++)
        begin
          t = (i == 4) ? 63 : $urandom % 63;
          trip_code <= 6'(t);
          bus(1'b0, OFS_TRIP, '0);
          chk("trip", (t > 62) ? 122 : 60 + t, rd);
        end
      end
      else
      begin
        mz(2, 1'b1, 1'b0, 300);
        bus(1'b0, OFS_TEMP + 8'h08, '0);
        chk("fault_hi", 8'h80, rd[15:8]);
        mz(0, 1'b0, 1'b1, 300);
        bus(1'b0, OFS_STAT, '0);
        chk("status", 32'h0000_000A, rd);
        chk("irq_masked", 0, irq);
        bus(1'b1, OFS_MASK, 32'h0000_0008);
        @(posedge clk);
        chk("irq_df", 1, irq);
        bus(1'b1, OFS_STAT, 32'h0000_000A);
        @(posedge clk);
        chk("irq_clr", 0, irq);
        for (int i = 0; i < 8; i++)
        begin
          bus(1'b1, OFS_CFG2, 32'(i));
          @(posedge clk);
          chk("avg_factor", i[2] ? (8 >> (i % 4)) : 1, avg_factor);
          chk("conv_rate", i % 4, conv_rate);
        end
        bus(1'b1, OFS_NONE, 32'hFFFF_FFFF);
        bus(1'b0, OFS_NONE, '0);
        chk("unmapped", 0, rd);
        chk("hresp", HRESP_OKAY, hresp);
      end
    end
    give_verdict();
  end
endmodule : tcs_shutdown_ctl_test
